// [arcm_pkg.sv]
/*
 arcm_pkg: constants for the reference range and margining register bank.
 Assumes a 32-bit classic Wishbone slave with byte addresses, one register per word.
*/
package arcm_pkg;
	// byte addresses of the registers
	localparam logic [7:0] ADDR_OFFSET_CAL_CONFIG = 8'h20;
	localparam logic [7:0] ADDR_REFERENCE_MARGIN_CONFIG = 8'h30;
	localparam logic [7:0] ADDR_STATUS = 8'h40;
	// reset values
	localparam logic [7:0] RST_OFFSET_CAL_CONFIG = 8'h00;
	localparam logic [7:0] RST_REFERENCE_MARGIN_CONFIG = 8'h00;
	// field positions and widths
	localparam int RANGE_SEL_LSB = 0;
	localparam int RANGE_SEL_W = 3;
	localparam int TRIM_LSB = 0;
	localparam int TRIM_W = 5;
	localparam int MARGIN_EN_BIT = 5;
	// writable masks, reserved bits are zero
	localparam logic [7:0] MASK_OFFSET_CAL_CONFIG = 8'h07;
	localparam logic [7:0] MASK_REFERENCE_MARGIN_CONFIG = 8'h3f;
	// reference range selection codes
	typedef enum logic [2:0] {
		ARCM_REF_5V0 = 3'b000,
		ARCM_REF_4V5 = 3'b001,
		ARCM_REF_4V096 = 3'b010,
		ARCM_REF_3V3 = 3'b011,
		ARCM_REF_3V0 = 3'b100,
		ARCM_REF_2V5 = 3'b101
	} arcm_ref_range_t;
endpackage

// [arcm_range_decode.sv]
/*
 arcm_range_decode: maps the 3-bit range-select code to the effective reference range.
 Assumes the code comes from a register on the same clock; purely combinational.
*/
`timescale 1ns/10ps
module arcm_range_decode (
	input wire logic [2:0] code_in,
	output arcm_pkg::arcm_ref_range_t range_out
);
	// codes above 2.5 V wrap back to the 5.0 V setting
	always_comb
	begin
		case (code_in)
			3'b001: range_out = arcm_pkg::ARCM_REF_4V5;
			3'b010: range_out = arcm_pkg::ARCM_REF_4V096;
			3'b011: range_out = arcm_pkg::ARCM_REF_3V3;
			3'b100: range_out = arcm_pkg::ARCM_REF_3V0;
			3'b101: range_out = arcm_pkg::ARCM_REF_2V5;
			default: range_out = arcm_pkg::ARCM_REF_5V0;
		endcase
	end
endmodule

// [arcm_regs.sv]
/*
 arcm_regs: reference range select and reference margining registers, Wishbone classic slave.
 Assumes a 32-bit classic Wishbone master on ref_clk_in and a synchronous high reset.
*/
`timescale 1ns/10ps
// Functional notes
// - offset cal register bits 7:3 always read zero
// - 3-bit range select in bits 2:0, reset 0; codes 6 and 7 mean 5.0 V
// - margining register at address 30h, resets to zero
// - margining register bits 7:6 always read zero
// - bit 5 enables margining, read/write, resets to zero
// - bits 4:0 signed trim code; 0-15 raise, 16-31 lower, 16 largest down
module arcm_regs (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	output logic wb_err_out,
	output logic [2:0] range_code_out,
	output logic [2:0] ref_range_out,
	output logic margin_enable_out,
	output logic [4:0] buffer_trim_code_out,
	output logic trim_lower_out,
	output logic [4:0] trim_step_out
);
	logic [7:0] offset_cal_config;
	logic [7:0] reference_margin_config;
	logic [31:0] next_dat;
	logic next_ack;
	logic next_err;
	logic [7:0] next_offset_cal_config;
	logic [7:0] next_reference_margin_config;
	logic [2:0] next_ref_range;
	logic next_trim_lower;
	logic [4:0] next_trim_step;
	arcm_pkg::arcm_ref_range_t dec_range;
	logic dec_lower;
	logic [4:0] dec_step;
	logic req;
	logic hit_cal;
	logic hit_mrg;
	logic hit_stat;

	arcm_range_decode u_range (
		.code_in(offset_cal_config[2:0]),
		.range_out(dec_range)
	);

	arcm_trim_decode u_trim (
		.code_in(reference_margin_config[4:0]),
		.lower_out(dec_lower),
		.step_out(dec_step)
	);

	// new request only while no ack or err is out, so each cycle gets one ack or err
	assign req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
	assign hit_cal = wb_adr_in == arcm_pkg::ADDR_OFFSET_CAL_CONFIG;
	assign hit_mrg = wb_adr_in == arcm_pkg::ADDR_REFERENCE_MARGIN_CONFIG;
	assign hit_stat = wb_adr_in == arcm_pkg::ADDR_STATUS;

	// register writes; byte lane 0 only, reserved bits masked off
	always_comb
	begin
		next_offset_cal_config = offset_cal_config;
		next_reference_margin_config = reference_margin_config;
		if (req && wb_we_in && wb_sel_in[0])
		begin
			if (hit_cal)
				next_offset_cal_config = wb_dat_in[7:0] & arcm_pkg::MASK_OFFSET_CAL_CONFIG;
			if (hit_mrg)
				next_reference_margin_config =
					wb_dat_in[7:0] & arcm_pkg::MASK_REFERENCE_MARGIN_CONFIG;
		end
	end

	// bus answer: ack on mapped offsets, err on anything else
	always_comb
	begin
		next_ack = 1'b0;
		next_err = 1'b0;
		next_dat = 32'h0000_0000;
		if (req)
		begin
			if (hit_cal || hit_mrg || hit_stat)
				next_ack = 1'b1;
			else
				next_err = 1'b1;
			if (!wb_we_in)
			begin
				if (hit_cal)
					next_dat = {24'h00_0000, 5'h00, offset_cal_config[2:0]};
				else if (hit_mrg)
					next_dat = {24'h00_0000, 2'b00, reference_margin_config[5:0]};
				else if (hit_stat)
					next_dat = {24'h00_0000, dec_lower, dec_step, ref_range_out[1:0]};
			end
		end
	end

	// decoded view, registered so outputs come from flops
	always_comb
	begin
		next_ref_range = dec_range;
		next_trim_lower = dec_lower;
		next_trim_step = dec_step;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			offset_cal_config <= arcm_pkg::RST_OFFSET_CAL_CONFIG;
			reference_margin_config <= arcm_pkg::RST_REFERENCE_MARGIN_CONFIG;
			wb_dat_out <= 32'h0000_0000;
			wb_ack_out <= 1'b0;
			wb_err_out <= 1'b0;
			ref_range_out <= 3'h0;
			trim_lower_out <= 1'b0;
			trim_step_out <= 5'h00;
		end
		else
		begin
			offset_cal_config <= next_offset_cal_config;
			reference_margin_config <= next_reference_margin_config;
			wb_dat_out <= next_dat;
			wb_ack_out <= next_ack;
			wb_err_out <= next_err;
			ref_range_out <= next_ref_range;
			trim_lower_out <= next_trim_lower;
			trim_step_out <= next_trim_step;
		end
	end

	// raw fields straight from the register flops
	assign range_code_out = offset_cal_config[2:0];
	assign margin_enable_out = reference_margin_config[arcm_pkg::MARGIN_EN_BIT];
	assign buffer_trim_code_out = reference_margin_config[4:0];
endmodule

// [arcm_regs_asserts.sv]
/* arcm_chk: port checks of the arcm_regs register bank.
 Assumes one clock and a master that holds address and we during ack. */
`timescale 1ns/10ps
module arcm_chk (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire logic [2:0] range_code_out,
	input wire logic [2:0] ref_range_out,
	input wire logic margin_enable_out,
	input wire logic [4:0] buffer_trim_code_out,
	input wire logic trim_lower_out,
	input wire logic [4:0] trim_step_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	// answer-cycle strobes; address is still held then
	wire logic rd = wb_ack_out && !wb_we_in;
	wire logic wr = wb_ack_out && wb_we_in && wb_sel_in[0];
	logic [4:0] tc;
	// decode lags the code by one flop
	always_ff @(posedge ref_clk_in)
	begin
		tc <= buffer_trim_code_out;
	end
	a_cal_rsvd_zero: assert property (
		rd && wb_adr_in == 8'h20 |-> wb_dat_out[31:3] == 29'h0)
		else $error("cal reserved bits set");
	a_range_map: assert property (
		ref_range_out == ($past(range_code_out) > 3'h5 ? 3'h0 : $past(range_code_out)))
		else $error("bad range map");
	a_cal_write: assert property (
		wr && wb_adr_in == 8'h20 |-> range_code_out == wb_dat_in[2:0])
		else $error("range not written");
	a_marg_write: assert property (
		wr && wb_adr_in == 8'h30 |-> {margin_enable_out, buffer_trim_code_out} == wb_dat_in[5:0])
		else $error("margin not written");
	a_marg_rsvd_zero: assert property (
		rd && wb_adr_in == 8'h30 |-> wb_dat_out[31:6] == 26'h0)
		else $error("margin reserved set");
	a_marg_readback: assert property (
		rd && wb_adr_in == 8'h30 |-> wb_dat_out[5:0] == {margin_enable_out, buffer_trim_code_out})
		else $error("margin readback");
	a_trim_decode: assert property (
		trim_lower_out == tc[4] && trim_step_out == (tc[4] ? 5'h10 - {1'h0, tc[3:0]} : tc))
		else $error("bad trim decode");
endmodule
bind arcm_regs arcm_chk chk (.*);

// [arcm_trim_decode.sv]
/*
 arcm_trim_decode: splits the 5-bit trim code into direction and magnitude step.
 Assumes the code comes from a register on the same clock; purely combinational.
*/
`timescale 1ns/10ps
module arcm_trim_decode (
	input wire logic [4:0] code_in,
	output logic lower_out,
	output logic [4:0] step_out
);
	// upper half lowers the output; 10000b is the largest step down
	always_comb
	begin
		lower_out = code_in[4];
		if (code_in[4])
			step_out = 5'h10 - {1'b0, code_in[3:0]};
		else
			step_out = code_in;
	end
endmodule

// [tb.sv]
/* tb: self-checking bench of arcm_regs over classic Wishbone.
 Assumes a one-cycle registered ack and the status word layout of the bank. */
`timescale 1ns/10ps
module tb;
	logic ref_clk_in = 1'h0, sys_rst_in = 1'h1, wb_cyc_in = 1'h0, wb_stb_in = 1'h0, wb_we_in = 1'h0;
	logic [7:0] wb_adr_in = 8'h0;
	logic [3:0] wb_sel_in = 4'h1;
	logic [31:0] wb_dat_in = 32'h0, wb_dat_out, s = 32'h39;
	logic wb_ack_out, wb_err_out;
	logic [32:0] q[$], e;
	int err_count = 0, n_tests = 0, ticks = 0;
	arcm_regs dut (.*, .range_code_out(), .ref_range_out(), .margin_enable_out(),
		.buffer_trim_code_out(), .trim_lower_out(), .trim_step_out());
	// 200 MHz clock
	initial forever #2.5 ref_clk_in = ~ref_clk_in;
	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic conclude();
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ack is read at the rising edge; release follows that edge, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_in <= 1'h1;
		wb_stb_in <= 1'h1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do @(posedge ref_clk_in); while (!(wb_ack_out | wb_err_out));
		wb_cyc_in <= 1'h0;
		wb_stb_in <= 1'h0;
		@(posedge ref_clk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		q.push_back(x);
		wb(1'h0, a, 32'h0);
	endtask
	// mid-cycle view of each answer, oldest note first
	always @(negedge ref_clk_in)
		if (wb_err_out || (wb_ack_out && !wb_we_in))
		begin
			n_tests++;
			e = q.pop_front();
			if (e !== {wb_err_out, wb_dat_out})
			begin
				err_count++;
				$display("CHECK FAILED %0t exp %h got %h", $time, e, {wb_err_out, wb_dat_out});
			end
		end
	// hang guard, far above the few hundred cycles needed
	always @(posedge ref_clk_in)
		if (++ticks > 3000)
		begin
			err_count++;
			conclude();
		end
	initial
	begin
		logic [31:0] r;
		logic [5:0] m;
		repeat (6) @(posedge ref_clk_in);
		sys_rst_in <= 1'h0;
		@(posedge ref_clk_in);
		rd(8'h20, 33'h0);
		rd(8'h30, 33'h0);
		// descending so range ends at code zero
		for (int i = 7; i >= 0; i--)
		begin
			r = xs();
			wb(1'h1, 8'h20, {r[31:3], 3'(i)});
			rd(8'h20, 33'(i));
		end
		// byte lane 0 disabled: the write is acked but must not land
		wb_sel_in <= 4'h0;
		wb(1'h1, 8'h20, 32'h0000_0005);
		wb_sel_in <= 4'h1;
		rd(8'h20, 33'h0);
		for (int i = 0; i < 32; i++)
		begin
			r = xs();
			m = {r[5], 5'(i)};
			wb(1'h1, 8'h30, {r[31:6], m});
			rd(8'h30, 33'(m));
			rd(8'h40, {25'h0, m[4], m[4] ? 5'h10 - 5'(i[3:0]) : 5'(i), 2'h0});
		end
		rd(8'h44, {1'h1, 32'h0});
		conclude();
	end
endmodule
